// ### array_drive_pkg_sync.sv
// Purpose: Shared constants and a two-flop synchroniser for the array drive sequencer
// Assumes: Host clock never exceeds its top rate; sensor timing is counted in host clocks
// Notes: The package is compiled ahead of every module that names it

// ============================================================
// Constants and types
package array_drive_pkg;
    // Host clock limits in kHz and the resulting shortest period
    localparam int HOST_CLK_MIN_KHZ = 30;
    localparam int HOST_CLK_MAX_KHZ = 500;
    localparam int HOST_PERIOD_MIN_NS = 1000000 / HOST_CLK_MAX_KHZ;
    // Element rate ceiling and typical value in kHz
    localparam int VIDEO_ELEMENT_RATE_KHZ = 250;
    localparam int VIDEO_ELEMENT_RATE_TYP_KHZ = 100;
    // Host clocks per element, chosen so the rate ceiling holds at top host rate
    localparam int ELEMENT_CLKS = (HOST_CLK_MAX_KHZ + VIDEO_ELEMENT_RATE_KHZ - 1)
        / VIDEO_ELEMENT_RATE_KHZ;
    // Least strobe widths, rounded up to host clocks at the fastest host clock
    localparam int RESET_MIN_NS = 15000;
    localparam int HOLD_MIN_NS = 1000;
    localparam int SAMPLE1_MIN_NS = 500;
    localparam int RESET_CLKS = (RESET_MIN_NS + HOST_PERIOD_MIN_NS - 1) / HOST_PERIOD_MIN_NS;
    localparam int HOLD_CLKS = (HOLD_MIN_NS + HOST_PERIOD_MIN_NS - 1) / HOST_PERIOD_MIN_NS;
    localparam int SAMPLE1_CLKS = (SAMPLE1_MIN_NS + HOST_PERIOD_MIN_NS - 1)
        / HOST_PERIOD_MIN_NS;
    // Scan start low time spans exactly one rise of the first phase
    localparam int START_LOW_CLKS = 2;
    localparam logic [7:0] STROBE_CNT_W8 = 8'(RESET_CLKS);
    // Default array length and video word width
    localparam int ELEMENTS_DEFAULT = 128;
    localparam int VIDEO_W_DEFAULT = 12;
    localparam int VIDEO_OFFSET_DEFAULT = 0;

    // Sequencer states, Gray coded along the frame path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SAMPLE = 3'h1,
        ST_HOLD = 3'h3,
        ST_RESET = 3'h2,
        ST_CLAMP = 3'h6,
        ST_START = 3'h7,
        ST_SCAN = 3'h5,
        ST_DRAIN = 3'h4
    } state_e;
endpackage

`timescale 1ns/1ps

// ============================================================
// Two flip-flop synchroniser
module cdc_sync2 #(
    parameter int W = 1
) (
    clk,
    d,
    q
);
    input wire logic clk;
    input wire logic [W-1:0] d;
    output logic [W-1:0] q;

    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end
endmodule

// ### linear_array_drive_sequencer.sv
// Purpose: Sensor drive timing generator for a linear photodiode array with charge amplifiers
// Assumes: hostClk is the host clock; videoIn comes from an on-board digitiser on hostClk
// Notes: Sequencing lives on hostClk; clock side only sees crossed video words
//
// Notes on behaviour
// - A host start pulse of one host clock or more initialises the sequence.
// - All sensor drive timing is derived synchronously from the host clock.
// - A positive trigger pulse tells the external converter when to convert.
// - Host end-of-scan output is the inverted sensor end-of-scan pulse.
// - Element rate never exceeds the ceiling; two host clocks per element.
// - The two scan clock phases are complementary logic pulses.
// - Scan start pulse is active low and begins a readout sweep.
// - Charge amplifier reset strobe is an active low pulse.
// - Hold strobe is an active high pulse moving charge into hold stage.
// - Clamp strobe is active high, sample strobe active low.
// - Gain select high chooses low gain, low chooses high gain.
// - Video above its offset is held once per element and forwarded.
// - Integration runs from reset strobe to hold strobe.
// - No hold strobe while the shift register is still scanning.
// - First phase rises exactly once while scan start is low, clocks running.
// - Elements follow second phase rises; end-of-scan precedes the last one.

`timescale 1ns/1ps

module linear_array_drive_sequencer #(
    parameter int ELEMENTS = array_drive_pkg::ELEMENTS_DEFAULT,
    parameter int VIDEO_W = array_drive_pkg::VIDEO_W_DEFAULT,
    parameter int VIDEO_OFFSET = array_drive_pkg::VIDEO_OFFSET_DEFAULT
) (
    clock,
    resetn,
    lowGain,
    videoOut,
    videoStrobe,
    busy,
    hostClk,
    hostStart,
    trigger,
    scanDonePulseN,
    videoIn,
    scanDonePulse,
    phi1,
    phi2,
    scanStartPulseN,
    ampResetN,
    ampHold,
    clampStrobe,
    sampleN,
    gainSel
);
    input wire logic clock;
    input wire logic resetn;
    input wire logic lowGain;
    output logic [VIDEO_W-1:0] videoOut;
    output logic videoStrobe;
    output logic busy;
    input wire logic hostClk;
    input wire logic hostStart;
    output logic trigger;
    output logic scanDonePulseN;
    input wire logic [VIDEO_W-1:0] videoIn;
    input wire logic scanDonePulse;
    output logic phi1;
    output logic phi2;
    output logic scanStartPulseN;
    output logic ampResetN;
    output logic ampHold;
    output logic clampStrobe;
    output logic sampleN;
    output logic gainSel;

    localparam int CNT_W = $clog2(ELEMENTS + 1);
    // ============================================================
    // Elaboration checks
    if (ELEMENTS < 2 || ELEMENTS > 4096 || VIDEO_W < 2 || VIDEO_W > 16
        || VIDEO_OFFSET < 0 || VIDEO_OFFSET >= (1 << VIDEO_W)) begin : g_bad_params
        $error("parameter out of range");
    end

    // Frame states where the shift register is still busy
    function automatic logic isScanning(array_drive_pkg::state_e s);
        return (s == array_drive_pkg::ST_SCAN) || (s == array_drive_pkg::ST_DRAIN);
    endfunction

    // ============================================================
    // Link side: synchronisers
    logic linkRstn;
    logic startSync;
    logic eosSync;
    logic lowGainLink;
    logic startSeen;

    // Reset, start, sensor end-of-scan and gain level into hostClk
    cdc_sync2 #(.W(4)) u_link_sync (
        .clk(hostClk),
        .d({resetn, hostStart, scanDonePulse, lowGain}),
        .q({linkRstn, startSync, eosSync, lowGainLink})
    );

    // ============================================================
    // Link side: sequencer
    array_drive_pkg::state_e state;
    array_drive_pkg::state_e next_state;
    logic [7:0] strobeCnt;
    logic [CNT_W-1:0] elemCnt;
    logic pending;
    logic vidTog;
    logic [VIDEO_W-1:0] videoHold;

    // Start edge and phase decode
    wire startEdge = startSync & ~startSeen;
    wire strobeDone = (strobeCnt == array_drive_pkg::STROBE_CNT_W8 - 8'h01);
    wire stDone = (strobeCnt == 8'(array_drive_pkg::START_LOW_CLKS - 1));
    wire cntZero = (next_state != state)
        || (state == array_drive_pkg::ST_START && scanStartPulseN);
    wire lastElem = trigger && (elemCnt == CNT_W'(ELEMENTS - 1));
    wire goFrame = startEdge | pending;
    wire [VIDEO_W-1:0] offsetW = VIDEO_W'(VIDEO_OFFSET);
    wire [VIDEO_W-1:0] videoAbove = (videoIn > offsetW) ? videoIn - offsetW : '0;

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            array_drive_pkg::ST_IDLE: begin
                if (goFrame) begin
                    next_state = array_drive_pkg::ST_SAMPLE;
                end
            end
            array_drive_pkg::ST_SAMPLE: begin
                next_state = array_drive_pkg::ST_HOLD;
            end
            array_drive_pkg::ST_HOLD: begin
                next_state = array_drive_pkg::ST_RESET;
            end
            array_drive_pkg::ST_RESET: begin
                if (strobeDone) begin
                    next_state = array_drive_pkg::ST_CLAMP;
                end
            end
            array_drive_pkg::ST_CLAMP: begin
                if (strobeDone) begin
                    next_state = array_drive_pkg::ST_START;
                end
            end
            array_drive_pkg::ST_START: begin
                if (!scanStartPulseN && stDone) begin
                    next_state = array_drive_pkg::ST_SCAN;
                end
            end
            array_drive_pkg::ST_SCAN: begin
                if (lastElem) begin
                    next_state = array_drive_pkg::ST_DRAIN;
                end
            end
            array_drive_pkg::ST_DRAIN: begin
                if (!eosSync) begin
                    next_state = array_drive_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = array_drive_pkg::ST_IDLE;
            end
        endcase
        // Start outside a readout restarts the frame at once
        if (startEdge && !isScanning(state)) begin
            next_state = array_drive_pkg::ST_SAMPLE;
        end
    end

    // State, counters and deferred start
    always_ff @(posedge hostClk) begin
        if (!linkRstn) begin
            state <= array_drive_pkg::ST_IDLE;
            strobeCnt <= 8'h00;
            elemCnt <= '0;
            pending <= 1'b0;
            startSeen <= 1'b0;
        end else begin
            state <= next_state;
            startSeen <= startSync;
            strobeCnt <= cntZero ? 8'h00 : strobeCnt + 8'h01;
            if (state != array_drive_pkg::ST_SCAN) begin
                elemCnt <= '0;
            end else if (trigger) begin
                elemCnt <= elemCnt + CNT_W'(1);
            end
            // Start during a readout waits; a new start wins over the clear
            if (startEdge && isScanning(state)) begin
                pending <= 1'b1;
            end else if (state == array_drive_pkg::ST_IDLE) begin
                pending <= 1'b0;
            end
        end
    end

    // Free running complementary phases, one element per two host clocks
    always_ff @(posedge hostClk) begin
        if (!linkRstn) begin
            phi1 <= 1'b0;
            phi2 <= 1'b1;
        end else begin
            phi1 <= ~phi1;
            phi2 <= phi1;
        end
    end

    // Sensor strobes decoded from the coming state
    always_ff @(posedge hostClk) begin
        if (!linkRstn) begin
            sampleN <= 1'b1;
            ampHold <= 1'b0;
            ampResetN <= 1'b1;
            clampStrobe <= 1'b0;
            gainSel <= 1'b1;
        end else begin
            sampleN <= !(next_state == array_drive_pkg::ST_SAMPLE
                || next_state == array_drive_pkg::ST_CLAMP);
            ampHold <= (next_state == array_drive_pkg::ST_HOLD) && !isScanning(state);
            ampResetN <= !(next_state == array_drive_pkg::ST_RESET);
            clampStrobe <= (next_state == array_drive_pkg::ST_CLAMP);
            gainSel <= lowGainLink;
        end
    end

    // Scan start low from a falling phase edge for two clocks
    always_ff @(posedge hostClk) begin
        if (!linkRstn) begin
            scanStartPulseN <= 1'b1;
        end else if (state == array_drive_pkg::ST_START && scanStartPulseN && phi1) begin
            scanStartPulseN <= 1'b0;
        end else if (!scanStartPulseN && stDone) begin
            scanStartPulseN <= 1'b1;
        end
    end

    // Trigger in the high half of the second phase, video held with it
    always_ff @(posedge hostClk) begin
        if (!linkRstn) begin
            trigger <= 1'b0;
            scanDonePulseN <= 1'b1;
            videoHold <= '0;
            vidTog <= 1'b0;
            busy <= 1'b0;
        end else begin
            trigger <= (next_state == array_drive_pkg::ST_SCAN) && phi1 && !lastElem;
            scanDonePulseN <= ~eosSync;
            busy <= (state != array_drive_pkg::ST_IDLE);
            if (trigger) begin
                videoHold <= videoAbove;
                vidTog <= ~vidTog;
            end
        end
    end

    // ============================================================
    // Clock side: video word crossing
    logic vidTogSync;
    logic vidTogSeen;

    // Toggle into clock; held word is stable for a whole element
    cdc_sync2 #(.W(1)) u_sys_sync (
        .clk(clock),
        .d(vidTog),
        .q(vidTogSync)
    );
    wire newWord = vidTogSync ^ vidTogSeen;

    // Present each element word with a one cycle strobe
    always_ff @(posedge clock) begin
        if (!resetn) begin
            vidTogSeen <= 1'b0;
            videoOut <= '0;
            videoStrobe <= 1'b0;
        end else begin
            vidTogSeen <= vidTogSync;
            videoStrobe <= newWord;
            if (newWord) begin
                videoOut <= videoHold;
            end
        end
    end

    // ============================================================
    // Checks on the link and clock sides
    logic [CNT_W:0] trigCount;

    // Triggers issued in the current readout
    always_ff @(posedge hostClk) begin
        if (!linkRstn || state == array_drive_pkg::ST_START) begin
            trigCount <= '0;
        end else if (trigger) begin
            trigCount <= trigCount + (CNT_W + 1)'(1);
        end
    end

    a_start_restarts: assert property (@(posedge hostClk) disable iff (!linkRstn)
        startEdge && !isScanning(state) |=> state == array_drive_pkg::ST_SAMPLE)
        else $error("start did not restart the frame");
    a_phase_complement: assert property (@(posedge hostClk) disable iff (!linkRstn)
        phi1 != phi2)
        else $error("scan phases not complementary");
    a_start_one_rise: assert property (@(posedge hostClk) disable iff (!linkRstn)
        $fell(scanStartPulseN) |-> !phi1 ##1 (phi1 && !scanStartPulseN)
            ##1 (scanStartPulseN && !phi1))
        else $error("first phase did not rise once under scan start");
    a_hold_not_scan: assert property (@(posedge hostClk) disable iff (!linkRstn)
        ampHold |-> !isScanning(state) && scanStartPulseN)
        else $error("hold strobe during readout");
    a_strobe_order: assert property (@(posedge hostClk) disable iff (!linkRstn)
        $rose(ampHold) |-> $rose(sampleN) ##1 ($fell(ampResetN) && !ampHold))
        else $error("sample hold reset order broken");
    a_reset_width: assert property (@(posedge hostClk) disable iff (!linkRstn)
        $fell(ampResetN) |-> (!ampResetN)[*8] ##1 (ampResetN && clampStrobe && !sampleN))
        else $error("reset strobe width or clamp follow wrong");
    a_trigger_half: assert property (@(posedge hostClk) disable iff (!linkRstn)
        trigger |-> phi2 && !phi1)
        else $error("trigger outside second phase high");
    a_trigger_rate: assert property (@(posedge hostClk) disable iff (!linkRstn)
        trigger |=> !trigger)
        else $error("element rate too high");
    a_trig_count: assert property (@(posedge hostClk) disable iff (!linkRstn)
        $rose(state == array_drive_pkg::ST_DRAIN) |-> trigCount == (CNT_W + 1)'(ELEMENTS))
        else $error("trigger count per readout wrong");
    a_eos_invert: assert property (@(posedge hostClk) disable iff (!linkRstn)
        $rose(eosSync) |=> $fell(scanDonePulseN))
        else $error("end of scan not inverted");
    a_word_strobe: assert property (@(posedge clock) disable iff (!resetn)
        videoStrobe |=> !videoStrobe)
        else $error("video strobe longer than one cycle");

    c_frame_done: cover property (@(posedge hostClk) disable iff (!linkRstn)
        state == array_drive_pkg::ST_DRAIN ##1 state == array_drive_pkg::ST_IDLE);
    c_start_deferred: cover property (@(posedge hostClk) disable iff (!linkRstn)
        startEdge && isScanning(state));
    c_restart: cover property (@(posedge hostClk) disable iff (!linkRstn)
        startEdge && state == array_drive_pkg::ST_CLAMP);
    c_word_out: cover property (@(posedge clock) disable iff (!resetn) videoStrobe);
endmodule

// ### sensor_array_model.sv
// Purpose: Behavioural linear array with shift register, video and end-of-scan output
// Assumes: Phases come from the sequencer; video is already digitised on the host clock
// Notes: Outside a scan the video bus shows a pattern that changes every host clock

`timescale 1ns/1ps

// ============================================================
// Array model
module sensor_array_model #(
    parameter int ELEMENTS = 4,
    parameter int VIDEO_W = 12
) (
    hostClk,
    phi1,
    phi2,
    scanStartPulseN,
    videoIn,
    scanDonePulse
);
    input wire logic hostClk;
    input wire logic phi1;
    input wire logic phi2;
    input wire logic scanStartPulseN;
    output logic [VIDEO_W-1:0] videoIn;
    output logic scanDonePulse;
    int idx = ELEMENTS;

    initial begin
        videoIn = '0;
        scanDonePulse = 1'b0;
    end
    // Shift register loads on the phi1 rise while scan start is low
    always @(posedge phi1) begin
        if (scanStartPulseN === 1'b0) begin
            idx = -1;
        end
    end
    // Next element on each phi2 rise; end-of-scan just before the last one
    always @(posedge phi2) begin
        if (idx < ELEMENTS) begin
            idx = idx + 1;
        end
        scanDonePulse = (idx == ELEMENTS - 1);
    end
    // Boxcar level above offset, settled a few ns after the edge
    always @(posedge hostClk) begin
        #5;
        if (idx >= 0 && idx < ELEMENTS) begin
            videoIn = VIDEO_W'(12'h100 + idx * 12'h011);
        end else begin
            videoIn = ~videoIn;
        end
    end
endmodule

// ### linear_array_drive_sequencer_tb.sv
// Purpose: Self-checking bench for the array drive sequencer with an array model
// Assumes: Four elements per frame; host clock of 48 ns beside a 20 ns system clock
// Notes: A host clock monitor tallies strobe widths, order and triggers per scenario

`timescale 1ns/1ps

// ============================================================
// Bench
module linear_array_drive_sequencer_tb;
    localparam int E = 4;
    logic clock = 1'b0;
    logic hostClk = 1'b0;
    logic resetn = 1'b0;
    logic lowGain = 1'b1;
    logic hostStart = 1'b0;
    logic [11:0] videoIn;
    logic scanDonePulse;
    logic [11:0] videoOut;
    logic videoStrobe, busy, trigger, scanDonePulseN, phi1, phi2, scanStartPulseN;
    logic ampResetN, ampHold, clampStrobe, sampleN, gainSel;
    logic pS, pH, pR, pC, pT, pP1, pTr, scanning;
    logic [39:0] order;
    int failures = 0;
    int cmp_count = 0;
    int holds, rLow, cHigh, sClamp, tLow, pRise, trigs, inScan, eIn, eOut, badPh, badTr;
    logic [11:0] words[$];

    linear_array_drive_sequencer #(.ELEMENTS(E)) linear_array_drive_sequencer_inst (
        .clock(clock), .resetn(resetn), .lowGain(lowGain), .videoOut(videoOut),
        .videoStrobe(videoStrobe), .busy(busy), .hostClk(hostClk), .hostStart(hostStart),
        .trigger(trigger), .scanDonePulseN(scanDonePulseN), .videoIn(videoIn),
        .scanDonePulse(scanDonePulse), .phi1(phi1), .phi2(phi2),
        .scanStartPulseN(scanStartPulseN), .ampResetN(ampResetN), .ampHold(ampHold),
        .clampStrobe(clampStrobe), .sampleN(sampleN), .gainSel(gainSel));
    sensor_array_model #(.ELEMENTS(E), .VIDEO_W(12)) sensor_array_model_inst (
        .hostClk(hostClk), .phi1(phi1), .phi2(phi2), .scanStartPulseN(scanStartPulseN),
        .videoIn(videoIn), .scanDonePulse(scanDonePulse));

    // ========================================================
    // Clocks, monitors and shared tasks
    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        #7;
        forever #24 hostClk = ~hostClk;
    end
    // Word capture on the system clock side
    always @(posedge clock) begin
        #1;
        if (videoStrobe === 1'b1) words.push_back(videoOut);
    end
    // Host clock tallies of strobes, phases and triggers
    always @(posedge hostClk) begin
        #1;
        if (sampleN === 1'b0 && pS === 1'b1 && clampStrobe !== 1'b1) order = {order[35:0], 4'h1};
        if (ampHold === 1'b1 && pH === 1'b0) order = {order[35:0], 4'h2};
        if (ampResetN === 1'b0 && pR === 1'b1) order = {order[35:0], 4'h3};
        if (clampStrobe === 1'b1 && pC === 1'b0) order = {order[35:0], 4'h4};
        if (scanStartPulseN === 1'b0 && pT === 1'b1) order = {order[35:0], 4'h5};
        if (scanStartPulseN === 1'b0) scanning = 1'b1;
        if (scanDonePulse === 1'b0 && eIn > 0) scanning = 1'b0;
        holds += int'(ampHold === 1'b1);
        rLow += int'(ampResetN === 1'b0);
        cHigh += int'(clampStrobe === 1'b1);
        sClamp += int'(sampleN === 1'b0 && clampStrobe === 1'b1);
        tLow += int'(scanStartPulseN === 1'b0);
        pRise += int'(phi1 === 1'b1 && pP1 === 1'b0 && scanStartPulseN === 1'b0);
        trigs += int'(trigger === 1'b1);
        inScan += int'(ampHold === 1'b1 && scanning === 1'b1);
        eIn += int'(scanDonePulse === 1'b1);
        eOut += int'(scanDonePulseN === 1'b0);
        badPh += int'(phi1 !== ~phi2 || phi1 === pP1);
        badTr += int'(trigger === 1'b1 && (phi1 !== 1'b0 || pTr === 1'b1));
        {pS, pH, pR, pC, pT, pP1, pTr} = {sampleN, ampHold, ampResetN, clampStrobe,
            scanStartPulseN, phi1, trigger};
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic clear_counts();
        {holds, rLow, cHigh, sClamp, tLow, pRise, trigs, inScan, eIn, eOut} = '0;
        {badPh, badTr} = '0;
        order = '0;
        scanning = 1'b0;
        words.delete();
    endtask

    task automatic pulse_start();
        @(posedge clock);
        hostStart <= 1'b1;
        repeat (3) @(posedge clock);
        hostStart <= 1'b0;
    endtask

    task automatic wait_done(input int target);
        int n;
        n = 0;
        while (!(trigs >= target && busy === 1'b0) && n < 400) begin
            @(posedge hostClk);
            n++;
        end
        if (n >= 400) failures++;
        repeat (6) @(posedge hostClk);
    endtask

    task automatic check_words(input int frames);
        check(words.size(), frames * E);
        foreach (words[i]) check(words[i], 12'h100 + (i % E) * 12'h011);
    endtask

    // ========================================================
    // Scenarios
    task automatic t_idle_levels();
        check({scanStartPulseN, ampResetN, ampHold}, 3'h6);
        check({clampStrobe, sampleN, trigger}, 3'h2);
        check({scanDonePulseN, busy, videoStrobe, gainSel}, 4'h9);
    endtask

    task automatic t_frame(input logic gainLow);
        @(posedge clock);
        lowGain <= gainLow;
        repeat (6) @(posedge hostClk);
        clear_counts();
        pulse_start();
        wait_done(E);
        check(order, 40'h12345);
        check({holds, rLow, cHigh, sClamp}, {32'd1, 32'd8, 32'd8, 32'd8});
        check({tLow, pRise}, {32'd2, 32'd1});
        check(trigs, E);
        check({badPh, badTr}, 64'h0);
        check({eIn, eOut}, {32'd2, 32'd2});
        check(gainSel, gainLow);
        check_words(1);
    endtask

    task automatic t_start_in_scan();
        int n;
        clear_counts();
        pulse_start();
        n = 0;
        while (trigs < 1 && n < 200) begin
            @(posedge hostClk);
            n++;
        end
        pulse_start();
        wait_done(2 * E);
        check(inScan, 0);
        check(order, 40'h12345_12345);
        check(trigs, 2 * E);
        check_words(2);
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog well beyond four frames
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (6) @(posedge hostClk);
        t_idle_levels();
        t_frame(1'b1);
        t_frame(1'b0);
        t_start_in_scan();
        tally_and_finish();
    end
endmodule
